// ===== pkg/temp_limit_pkg.sv
package temp_limit_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int TEMP_W = 8;
    localparam int ADR_W  = 8;
    localparam int DAT_W  = 32;

    typedef logic signed [TEMP_W-1:0] temp_t;
    typedef logic [TEMP_W-1:0]        hyst_t;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADR_W-1:0] REG_CTRL        = 8'h00;
    localparam logic [ADR_W-1:0] REG_STATUS      = 8'h04;
    localparam logic [ADR_W-1:0] REG_LOCAL_HIGH  = 8'h08;
    localparam logic [ADR_W-1:0] REG_LOCAL_LOW   = 8'h0c;
    localparam logic [ADR_W-1:0] REG_REMOTE_HIGH = 8'h10;
    localparam logic [ADR_W-1:0] REG_REMOTE_LOW  = 8'h14;
    localparam logic [ADR_W-1:0] REG_LOCAL_FS    = 8'h18;
    localparam logic [ADR_W-1:0] REG_REMOTE_FS   = 8'h1c;
    localparam logic [ADR_W-1:0] REG_HYST        = 8'h20;
    localparam logic [ADR_W-1:0] REG_OFFSET      = 8'h24;
    localparam logic [ADR_W-1:0] REG_LOCAL_RES   = 8'h28;
    localparam logic [ADR_W-1:0] REG_REMOTE_RES  = 8'h2c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_W         = 2;
    localparam int CTRL_MASK_BIT  = 0;
    localparam int CTRL_MODE_BIT  = 1;
    localparam int STATUS_W       = 7;
    localparam int ST_REMOTE_FS   = 0;
    localparam int ST_LOCAL_FS    = 1;
    localparam int ST_OPEN        = 2;
    localparam int ST_REMOTE_LOW  = 3;
    localparam int ST_REMOTE_HIGH = 4;
    localparam int ST_LOCAL_LOW   = 5;
    localparam int ST_LOCAL_HIGH  = 6;
    localparam logic [STATUS_W-1:0] ST_ALERT_MASK = 7'h7c;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
    localparam temp_t FS_LIMIT_RST = 8'sh55;
    localparam temp_t HIGH_RST     = 8'sh7f;
    localparam temp_t LOW_RST      = 8'sh80;
    localparam hyst_t HYST_RST     = 8'h0a;
    localparam temp_t OFFSET_RST   = 8'sh00;
    localparam temp_t TEMP_MAX     = 8'sh7f;
    localparam temp_t TEMP_MIN     = 8'sh80;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        temp_t high;
        temp_t low;
        temp_t failsafe;
    } chan_limits_t;

    typedef struct packed {
        logic high;
        logic low;
        logic failsafe;
        logic secondary;
    } cmp_flags_t;

endpackage

// ===== hdl/temp_chan_compare.sv
`timescale 1ns/1ns
module temp_chan_compare
(
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       ce_i,
    // Evaluation request
    input  wire logic                       upd_i,
    input  wire temp_limit_pkg::temp_t      temp_i,
    input  wire temp_limit_pkg::chan_limits_t lim_i,
    input  wire temp_limit_pkg::hyst_t      hyst_i,
    // Flags
    output temp_limit_pkg::cmp_flags_t      flags_o
);

    // ------------------------------------------------------------
    // Release test: temperature at or below limit minus hysteresis
    // ------------------------------------------------------------
    function automatic logic at_release(input temp_limit_pkg::temp_t t,
                                        input temp_limit_pkg::temp_t lim,
                                        input temp_limit_pkg::hyst_t hy);
        logic signed [9:0] rel;
        logic signed [9:0] tw;
        rel = $signed({{2{lim[7]}}, lim}) - $signed({2'b00, hy});
        tw  = $signed({{2{t[7]}}, t});
        return tw <= rel;
    endfunction

    temp_limit_pkg::cmp_flags_t state_r;
    temp_limit_pkg::cmp_flags_t state_nxt;

    // Compare only at update points
    always_comb
    begin
        state_nxt = state_r;
        if (upd_i)
        begin
            state_nxt.high = temp_i > lim_i.high;
            state_nxt.low  = temp_i <= lim_i.low;
            if (temp_i > lim_i.failsafe)
                state_nxt.failsafe = 1'b1;
            else if (at_release(temp_i, lim_i.failsafe, hyst_i))
                state_nxt.failsafe = 1'b0;
            if (temp_i > lim_i.high)
                state_nxt.secondary = 1'b1;
            else if (at_release(temp_i, lim_i.high, hyst_i))
                state_nxt.secondary = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_r <= '0;
        else if (ce_i)
            state_r <= state_nxt;
    end

    assign flags_o = state_r;

endmodule // temp_chan_compare

// ===== hdl/temp_limit_interrupt_logic.sv
// How it works
// - Limit interrupt asserts when either channel is above high or at/below low limit.
// - Open remote diode also asserts the limit interrupt.
// - Interrupt releases after alert response, condition gone and status flags cleared.
// - A control bit masks the limit interrupt.
// - Fail-safe output has no mask of any kind.
// - Fail-safe output asserts when either channel exceeds its fail-safe limit.
// - Fail-safe output releases alone at fail-safe limit minus hysteresis.
// - One hysteresis value serves both local and remote channels.
// - Both fail-safe limits reset to 85 degrees.
// - Hysteresis resets to 10, unsigned one degree per count, writable.
// - Control bit selects shared pin as limit interrupt or second over-temperature.
// - Second over-temperature asserts when either channel exceeds its high limit.
// - Second over-temperature clears itself with same hysteresis, no mask.
// - Offset is added to each measurement before it is used.
// - Open flag at status bit 2 is set at conversion start.
`timescale 1ns/1ns
module temp_limit_interrupt_logic
(
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Measurement side
    input  wire logic        conv_start_i,
    input  wire logic        open_fault_i,
    input  wire logic        result_valid_i,
    input  wire logic [7:0]  local_temp_i,
    input  wire logic [7:0]  remote_temp_i,
    // Bus alert-response event
    input  wire logic        alert_resp_done_i,
    // Open-drain pins
    output logic             failsafe_overtemp_n_o,
    output logic             failsafe_overtemp_n_oe_o,
    output logic             alert_or_secondary_n_o,
    output logic             alert_or_secondary_n_oe_o
);

    // ------------------------------------------------------------
    // Types and helpers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [temp_limit_pkg::CTRL_W-1:0]   ctrl;
        logic [temp_limit_pkg::STATUS_W-1:0] status;
        temp_limit_pkg::chan_limits_t        lim_local;
        temp_limit_pkg::chan_limits_t        lim_remote;
        temp_limit_pkg::hyst_t               hyst;
        temp_limit_pkg::temp_t               offset;
        temp_limit_pkg::temp_t               res_local;
        temp_limit_pkg::temp_t               res_remote;
        logic                                upd;
        logic                                cmp_done;
        logic                                alert_pend;
        logic                                fs_oe;
        logic                                shared_oe;
        logic                                ack;
        logic [31:0]                         dat;
    } state_t;

    // Register address hit
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        return adr == off;
    endfunction

    // Offset correction with saturation
    function automatic temp_limit_pkg::temp_t add_offset(input logic [7:0] raw,
                                                        input temp_limit_pkg::temp_t off);
        logic signed [8:0] sum;
        sum = $signed({raw[7], raw}) + $signed({off[7], off});
        if (sum > $signed({1'b0, temp_limit_pkg::TEMP_MAX}))
            return temp_limit_pkg::TEMP_MAX;
        else if (sum < $signed({1'b1, temp_limit_pkg::TEMP_MIN}))
            return temp_limit_pkg::TEMP_MIN;
        else
            return temp_limit_pkg::temp_t'(sum[7:0]);
    endfunction

    // Zero-extend a byte onto the data bus
    function automatic logic [31:0] rd_byte(input logic [7:0] b);
        return {24'h000000, b};
    endfunction

    state_t                     state_r;
    state_t                     state_nxt;
    temp_limit_pkg::cmp_flags_t flags_local;
    temp_limit_pkg::cmp_flags_t flags_remote;
    temp_limit_pkg::cmp_flags_t chan_flags [2];
    temp_limit_pkg::temp_t      chan_temp  [2];
    temp_limit_pkg::chan_limits_t chan_lim [2];

    // ------------------------------------------------------------
    // Channel comparators
    // ------------------------------------------------------------
    assign chan_temp[0] = state_r.res_local;
    assign chan_temp[1] = state_r.res_remote;
    assign chan_lim[0]  = state_r.lim_local;
    assign chan_lim[1]  = state_r.lim_remote;

    generate
        for (genvar ch = 0; ch < 2; ch++)
        begin : g_chan
            temp_chan_compare u_cmp
            (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .ce_i    (ce_i),
                .upd_i   (state_r.upd),
                .temp_i  (chan_temp[ch]),
                .lim_i   (chan_lim[ch]),
                .hyst_i  (state_r.hyst),
                .flags_o (chan_flags[ch])
            );
        end
    endgenerate

    assign flags_local  = chan_flags[0];
    assign flags_remote = chan_flags[1];

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic                                bus_req;
    logic                                bus_wr;
    logic [temp_limit_pkg::STATUS_W-1:0] st_set;
    logic [temp_limit_pkg::STATUS_W-1:0] st_clr;
    logic                                cond_now;
    logic                                evt_set;

    // Bus request strobes, byte lane 0 holds all data
    always_comb
    begin
        bus_req = wb_cyc_i && wb_stb_i && !state_r.ack;
        bus_wr  = bus_req && wb_we_i && wb_sel_i[0];
    end

    // Status set and clear terms
    always_comb
    begin
        st_set = '0;
        st_clr = '0;
        if (state_r.cmp_done)
        begin
            st_set[temp_limit_pkg::ST_LOCAL_HIGH]  = flags_local.high;
            st_set[temp_limit_pkg::ST_LOCAL_LOW]   = flags_local.low;
            st_set[temp_limit_pkg::ST_REMOTE_HIGH] = flags_remote.high;
            st_set[temp_limit_pkg::ST_REMOTE_LOW]  = flags_remote.low;
            st_set[temp_limit_pkg::ST_LOCAL_FS]    = flags_local.failsafe;
            st_set[temp_limit_pkg::ST_REMOTE_FS]   = flags_remote.failsafe;
        end
        if (conv_start_i && open_fault_i)
            st_set[temp_limit_pkg::ST_OPEN] = 1'b1;
        if (bus_wr && hit(wb_adr_i, temp_limit_pkg::REG_STATUS))
            st_clr = wb_dat_i[temp_limit_pkg::STATUS_W-1:0];
        // Alert sources: limit violations and open diode
        evt_set  = |(st_set & temp_limit_pkg::ST_ALERT_MASK);
        cond_now = flags_local.high || flags_local.low || flags_remote.high || flags_remote.low;
    end

    // Main state update
    always_comb
    begin
        state_nxt          = state_r;
        state_nxt.ack      = bus_req;
        state_nxt.upd      = 1'b0;
        state_nxt.cmp_done = state_r.upd;

        // New results, offset applied first
        if (result_valid_i)
        begin
            state_nxt.res_local  = add_offset(local_temp_i, state_r.offset);
            state_nxt.res_remote = add_offset(remote_temp_i, state_r.offset);
            state_nxt.upd        = 1'b1;
        end

        // Sticky status, a set wins over a clear
        state_nxt.status = (state_r.status & ~st_clr) | st_set;

        // Alert latch: released only after alert response with nothing pending
        if (evt_set)
            state_nxt.alert_pend = 1'b1;
        else if (alert_resp_done_i && !cond_now
                 && ((state_r.status & temp_limit_pkg::ST_ALERT_MASK) == '0))
            state_nxt.alert_pend = 1'b0;

        // Fail-safe pin follows comparator state at update points, shared pin updates every cycle
        if (state_r.cmp_done)
        begin
            state_nxt.fs_oe = flags_local.failsafe || flags_remote.failsafe;
        end
        if (state_r.ctrl[temp_limit_pkg::CTRL_MODE_BIT])
            state_nxt.shared_oe = flags_local.secondary || flags_remote.secondary;
        else
            state_nxt.shared_oe = state_nxt.alert_pend
                                  && !state_r.ctrl[temp_limit_pkg::CTRL_MASK_BIT];

        // Register writes
        if (bus_wr)
        begin
            if (hit(wb_adr_i, temp_limit_pkg::REG_CTRL))
                state_nxt.ctrl = wb_dat_i[temp_limit_pkg::CTRL_W-1:0];
            if (hit(wb_adr_i, temp_limit_pkg::REG_LOCAL_HIGH))
                state_nxt.lim_local.high = wb_dat_i[7:0];
            if (hit(wb_adr_i, temp_limit_pkg::REG_LOCAL_LOW))
                state_nxt.lim_local.low = wb_dat_i[7:0];
            if (hit(wb_adr_i, temp_limit_pkg::REG_REMOTE_HIGH))
                state_nxt.lim_remote.high = wb_dat_i[7:0];
            if (hit(wb_adr_i, temp_limit_pkg::REG_REMOTE_LOW))
                state_nxt.lim_remote.low = wb_dat_i[7:0];
            if (hit(wb_adr_i, temp_limit_pkg::REG_LOCAL_FS))
                state_nxt.lim_local.failsafe = wb_dat_i[7:0];
            if (hit(wb_adr_i, temp_limit_pkg::REG_REMOTE_FS))
                state_nxt.lim_remote.failsafe = wb_dat_i[7:0];
            if (hit(wb_adr_i, temp_limit_pkg::REG_HYST))
                state_nxt.hyst = wb_dat_i[7:0];
            if (hit(wb_adr_i, temp_limit_pkg::REG_OFFSET))
                state_nxt.offset = wb_dat_i[7:0];
        end

        // Read data, unmapped reads as zero
        state_nxt.dat = '0;
        if (bus_req && !wb_we_i)
        begin
            if (hit(wb_adr_i, temp_limit_pkg::REG_CTRL))
                state_nxt.dat = {30'h00000000, state_r.ctrl};
            if (hit(wb_adr_i, temp_limit_pkg::REG_STATUS))
                state_nxt.dat = {25'h0000000, state_r.status};
            if (hit(wb_adr_i, temp_limit_pkg::REG_LOCAL_HIGH))
                state_nxt.dat = rd_byte(state_r.lim_local.high);
            if (hit(wb_adr_i, temp_limit_pkg::REG_LOCAL_LOW))
                state_nxt.dat = rd_byte(state_r.lim_local.low);
            if (hit(wb_adr_i, temp_limit_pkg::REG_REMOTE_HIGH))
                state_nxt.dat = rd_byte(state_r.lim_remote.high);
            if (hit(wb_adr_i, temp_limit_pkg::REG_REMOTE_LOW))
                state_nxt.dat = rd_byte(state_r.lim_remote.low);
            if (hit(wb_adr_i, temp_limit_pkg::REG_LOCAL_FS))
                state_nxt.dat = rd_byte(state_r.lim_local.failsafe);
            if (hit(wb_adr_i, temp_limit_pkg::REG_REMOTE_FS))
                state_nxt.dat = rd_byte(state_r.lim_remote.failsafe);
            if (hit(wb_adr_i, temp_limit_pkg::REG_HYST))
                state_nxt.dat = rd_byte(state_r.hyst);
            if (hit(wb_adr_i, temp_limit_pkg::REG_OFFSET))
                state_nxt.dat = rd_byte(state_r.offset);
            if (hit(wb_adr_i, temp_limit_pkg::REG_LOCAL_RES))
                state_nxt.dat = rd_byte(state_r.res_local);
            if (hit(wb_adr_i, temp_limit_pkg::REG_REMOTE_RES))
                state_nxt.dat = rd_byte(state_r.res_remote);
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r                     <= '0;
            state_r.ctrl                <= temp_limit_pkg::CTRL_RST;
            state_r.lim_local.high      <= temp_limit_pkg::HIGH_RST;
            state_r.lim_local.low       <= temp_limit_pkg::LOW_RST;
            state_r.lim_local.failsafe  <= temp_limit_pkg::FS_LIMIT_RST;
            state_r.lim_remote.high     <= temp_limit_pkg::HIGH_RST;
            state_r.lim_remote.low      <= temp_limit_pkg::LOW_RST;
            state_r.lim_remote.failsafe <= temp_limit_pkg::FS_LIMIT_RST;
            state_r.hyst                <= temp_limit_pkg::HYST_RST;
            state_r.offset              <= temp_limit_pkg::OFFSET_RST;
        end
        else if (ce_i)
        begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs, open-drain: data low, enable while asserted
    // ------------------------------------------------------------
    assign wb_ack_o                  = state_r.ack;
    assign wb_dat_o                  = state_r.dat;
    assign failsafe_overtemp_n_o     = 1'b0;
    assign failsafe_overtemp_n_oe_o  = state_r.fs_oe;
    assign alert_or_secondary_n_o    = 1'b0;
    assign alert_or_secondary_n_oe_o = state_r.shared_oe;

endmodule // temp_limit_interrupt_logic

// ===== tb/temp_limit_properties.sv
`timescale 1ns/1ns
module temp_limit_checker
(
    // Clock and reset
    input wire logic        clk_i, rst_i,
    // Register bus
    input wire logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i, wb_dat_o,
    // Measurement events and pins
    input wire logic        conv_start_i, open_fault_i, result_valid_i, alert_resp_done_i,
    input wire logic        failsafe_overtemp_n_o, failsafe_overtemp_n_oe_o,
    input wire logic        alert_or_secondary_n_o, alert_or_secondary_n_oe_o
);
    logic [1:0] ctrl_r;

    // Shadow of the control register, taken at the ack edge
    always_ff @(posedge clk_i)
        if (rst_i)
            ctrl_r <= 2'h0;
        else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == temp_limit_pkg::REG_CTRL)
            ctrl_r <= wb_dat_i[1:0];

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Bus request and open-diode event
    sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence open_s; conv_start_i && open_fault_i && ctrl_r == 2'h0; endsequence

    ack_follows_req_a: assert property (req_s |=> wb_ack_o) else $error("no ack after request");
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    read_upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
    pins_drive_low_a: assert property (!failsafe_overtemp_n_o && !alert_or_secondary_n_o)
        else $error("pin driven high");
    fs_moves_on_result_a: assert property ($changed(failsafe_overtemp_n_oe_o) && !$past(rst_i)
        |-> $past(result_valid_i, 2) || $past(result_valid_i, 3)) else $error("fail-safe moved off update");
    shared_moves_on_cause_a: assert property ($changed(alert_or_secondary_n_oe_o) && !$past(rst_i) |->
        $past(result_valid_i, 2) || $past(result_valid_i, 3) || $past(conv_start_i) || $past(conv_start_i, 2)
        || $past(alert_resp_done_i) || $past(alert_resp_done_i, 2) || $past(wb_ack_o) || $past(wb_ack_o, 2)
        || $past(wb_ack_o, 3)) else $error("shared pin moved without cause");
    open_raises_alert_a: assert property (open_s |-> ##[2:3] alert_or_secondary_n_oe_o)
        else $error("open diode left alert idle");
    mask_silences_alert_a: assert property ((ctrl_r == 2'h1) [*4] |-> !alert_or_secondary_n_oe_o)
        else $error("masked alert still driven");
endmodule // temp_limit_checker

bind temp_limit_interrupt_logic temp_limit_checker temp_limit_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .conv_start_i(conv_start_i),
    .open_fault_i(open_fault_i), .result_valid_i(result_valid_i), .alert_resp_done_i(alert_resp_done_i),
    .failsafe_overtemp_n_o(failsafe_overtemp_n_o), .failsafe_overtemp_n_oe_o(failsafe_overtemp_n_oe_o),
    .alert_or_secondary_n_o(alert_or_secondary_n_o), .alert_or_secondary_n_oe_o(alert_or_secondary_n_oe_o));

// ===== tb/fan_host_model.sv
`timescale 1ns/1ns
module fan_host_model
(
    // Clock
    input  wire logic clk_i,
    // Pin enables from the device
    input  wire logic failsafe_oe_i,
    input  wire logic shared_oe_i,
    // Service request from the bench
    input  wire logic service_i,
    // Resolved pin levels and alert-response event
    output logic      failsafe_level_o,
    output logic      shared_level_o,
    output logic      alert_resp_done_o
);
    // Pull-ups: a released pin reads high
    assign failsafe_level_o = failsafe_oe_i ? 1'b0 : 1'b1;
    assign shared_level_o   = shared_oe_i ? 1'b0 : 1'b1;

    // Alert-response read answered only while the device holds the line low
    initial alert_resp_done_o = 1'b0;
    always @(posedge clk_i)
        alert_resp_done_o <= service_i && !shared_level_o;
endmodule // fan_host_model

// ===== tb/temp_limit_interrupt_logic_bench.sv
`timescale 1ns/1ns
module temp_limit_interrupt_logic_bench;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc = 1'b0, wb_we = 1'b0, conv_start = 1'b0;
    logic        open_fault = 1'b0, res_valid = 1'b0, service = 1'b0;
    logic [7:0]  wb_adr = 8'h00, loc_t = 8'h00, rem_t = 8'h00;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0, wb_rdat, rd_v;
    logic        wb_ack, fs_oe, sh_oe, fs_lvl, sh_lvl, ara_done;
    int          errors = 0, total_checks = 0;

    // Clock
    always #5 clk_i = ~clk_i;

    temp_limit_interrupt_logic temp_limit_interrupt_logic_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .conv_start_i(conv_start),
        .open_fault_i(open_fault), .result_valid_i(res_valid), .local_temp_i(loc_t), .remote_temp_i(rem_t),
        .alert_resp_done_i(ara_done), .failsafe_overtemp_n_o(), .failsafe_overtemp_n_oe_o(fs_oe),
        .alert_or_secondary_n_o(), .alert_or_secondary_n_oe_o(sh_oe));
    fan_host_model fan_host_model_inst (.clk_i(clk_i), .failsafe_oe_i(fs_oe), .shared_oe_i(sh_oe),
        .service_i(service), .failsafe_level_o(fs_lvl), .shared_level_o(sh_lvl), .alert_resp_done_o(ara_done));

    // Verdict
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // Classic single Wishbone cycle, held until ack is sampled
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= 4'h1;
        wb_wdat <= wd;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 20);
        rd_v = wb_rdat;
        wb_cyc <= 1'b0;
        @(posedge clk_i);
        if (n >= 20)
        begin
            errors++;
            tally_and_finish();
        end
    endtask

    task automatic rd_check(input logic [7:0] adr, input logic [31:0] exp, input string what);
        bus(1'b0, adr, 32'h0);
        check(what, rd_v, exp);
    endtask

    // One measurement pair, then let flags and pins settle
    task automatic result(input logic [7:0] l, input logic [7:0] r);
        loc_t <= l;
        rem_t <= r;
        res_valid <= 1'b1;
        @(posedge clk_i);
        res_valid <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    // Host performs the alert-response read
    task automatic ara();
        service <= 1'b1;
        @(posedge clk_i);
        service <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    task automatic reset_values();
        rd_check(temp_limit_pkg::REG_LOCAL_FS, 32'h55, "local fs limit");
        rd_check(temp_limit_pkg::REG_REMOTE_FS, 32'h55, "remote fs limit");
        rd_check(temp_limit_pkg::REG_HYST, 32'h0a, "hysteresis");
        rd_check(8'h3c, 32'h0, "unmapped");
    endtask

    task automatic failsafe_path();
        result(8'h56, 8'h00);
        check("fs over", fs_lvl, 1'b0);
        bus(1'b1, temp_limit_pkg::REG_CTRL, 32'h1);
        result(8'h50, 8'h00);
        check("fs masked in band", fs_lvl, 1'b0);
        result(8'h4b, 8'h00);
        check("fs released", fs_lvl, 1'b1);
        bus(1'b1, temp_limit_pkg::REG_HYST, 32'h3);
        result(8'h00, 8'h56);
        result(8'h00, 8'h53);
        check("remote fs in band", fs_lvl, 1'b0);
        result(8'h00, 8'h52);
        check("remote fs released", fs_lvl, 1'b1);
        result(8'h00, 8'h80);
        check("masked alert", sh_lvl, 1'b1);
        result(8'h00, 8'h00);
        bus(1'b1, temp_limit_pkg::REG_STATUS, 32'h7f);
    endtask

    task automatic alert_path();
        bus(1'b1, temp_limit_pkg::REG_CTRL, 32'h0);
        check("latched alert unmasked", sh_lvl, 1'b0);
        ara();
        check("latched alert released", sh_lvl, 1'b1);
        bus(1'b1, temp_limit_pkg::REG_LOCAL_HIGH, 32'h32);
        result(8'h33, 8'h00);
        check("alert on high", sh_lvl, 1'b0);
        result(8'h28, 8'h00);
        ara();
        check("alert kept, status set", sh_lvl, 1'b0);
        bus(1'b1, temp_limit_pkg::REG_STATUS, 32'h7f);
        ara();
        check("alert released", sh_lvl, 1'b1);
        bus(1'b1, temp_limit_pkg::REG_LOCAL_LOW, 32'h14);
        result(8'h14, 8'h00);
        check("alert at low", sh_lvl, 1'b0);
        result(8'h1e, 8'h00);
        bus(1'b1, temp_limit_pkg::REG_STATUS, 32'h7f);
        ara();
        check("alert released again", sh_lvl, 1'b1);
    endtask

    task automatic open_path();
        conv_start <= 1'b1;
        open_fault <= 1'b1;
        @(posedge clk_i);
        conv_start <= 1'b0;
        open_fault <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd_check(temp_limit_pkg::REG_STATUS, 32'h04, "open flag");
        check("alert on open", sh_lvl, 1'b0);
        bus(1'b1, temp_limit_pkg::REG_STATUS, 32'h7f);
        ara();
        check("open alert released", sh_lvl, 1'b1);
    endtask

    task automatic secondary_path();
        bus(1'b1, temp_limit_pkg::REG_CTRL, 32'h3);
        result(8'h33, 8'h00);
        check("secondary on", sh_lvl, 1'b0);
        result(8'h30, 8'h00);
        check("secondary in band", sh_lvl, 1'b0);
        result(8'h2f, 8'h00);
        check("secondary released", sh_lvl, 1'b1);
    endtask

    task automatic offset_path();
        bus(1'b1, temp_limit_pkg::REG_OFFSET, 32'hfb);
        result(8'h37, 8'h80);
        rd_check(temp_limit_pkg::REG_LOCAL_RES, 32'h32, "local with offset");
        rd_check(temp_limit_pkg::REG_REMOTE_RES, 32'h80, "remote saturated");
    endtask

    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        reset_values();
        failsafe_path();
        alert_path();
        open_path();
        secondary_path();
        offset_path();
        tally_and_finish();
    end
endmodule // temp_limit_interrupt_logic_bench
